// file: verilog/uepbc_params.svh
`ifndef UEPBC_PARAMS_SVH
`define UEPBC_PARAMS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define UEPBC_CMD_CNT_WR 8'hf2
`define UEPBC_CMD_CNT_RD 8'hf3
`define UEPBC_CMD_SOFT_RST 8'hf6
`define UEPBC_CMD_STAT_HI 4'h5
// ----------------------------------------
// field positions
// ----------------------------------------
`define UEPBC_CFG_RUN_BIT 3
`define UEPBC_CFG_CTE_BIT 15
`define UEPBC_ST_HALT 7
`define UEPBC_ST_FULL1 6
`define UEPBC_ST_FULL0 5
`define UEPBC_ST_TOGGLE 4
`define UEPBC_ST_CLOB 3
`define UEPBC_ST_SETUP 2
`define UEPBC_ST_CPU_BUFFER_SELECT 1
// ----------------------------------------
// reset values and steps
// ----------------------------------------
`define UEPBC_CNT_RST 16'h0000
`define UEPBC_STAT_RST 8'h00
`define UEPBC_PTR_STEP 11'h002
`define UEPBC_DMA_START 11'h002
`endif

// file: verilog/uepbc_pkg.sv
`default_nettype none
package uepbc_pkg;
  // data phase expected after the last command
  typedef enum logic [2:0] {
    UEPBC_IDLE = 3'b000,
    UEPBC_CNT_W = 3'b001,
    UEPBC_CNT_R = 3'b010,
    UEPBC_STAT = 3'b011,
    UEPBC_BUF_W = 3'b100,
    UEPBC_BUF_R = 3'b101
  } uepbc_phase_e;
  typedef logic [10:0] uepbc_ptr_t;
endpackage
`default_nettype wire

// file: verilog/uepbc_core.sv
// What this block does
// - command f2 writes dma byte counter, f3 reads it back as a word
// - counter read returns bytes still outstanding, not programmed value
// - counter clears on hardware reset, bus reset leaves it unchanged
// - enabling dma reloads the working counter from the programmed counter
// - command f6 resets the block just like a hardware reset
// - buffer command rewinds pointer, each word access advances it by 2
// - codes 01-0f select buffer writes, 10 and 12-1f buffer reads
// - word 0 holds packet length, then two bytes per word, odd low
// - dma skips the length word and starts at the second word
// - buffer reads flag the final word from the packet length
// - bulk and interrupt in buffers are sent only once filled
// - external end of transfer sends the buffer whether full or not
// - select high is a command on low byte, select low is 16-bit data
// - dma moves to the secondary buffer at the end of the primary
// - codes 50-5f return the 8-bit read-only endpoint status word
// - status read clears that endpoint's pending interrupt flag
// - bits 6 and 5 show buffer full, bit 1 shows cpu buffer
// - bit 4 shows next toggle, bit 2 shows a setup packet held
// - bit 3 set on setup setup_clobbered, cleared by read once written
// - run bit 3 starts dma, 0 stops it, bus reset clears it
// - with bit 15 set, counter reaching zero raises end of transfer
`timescale 1ns/1ns
`default_nettype none
`include "uepbc_params.svh"
module uepbc_core
  import uepbc_pkg::*;
#(
  parameter int BUF_BYTES = 64
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // processor port
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic command_data_select_i,
  input wire logic [15:0] cpu_data_i,
  output logic [15:0] cpu_data_o,
  output logic cpu_rvalid_o,
  // endpoint buffer port
  output logic [3:0] buf_ep_o,
  output logic [10:0] buf_addr_o,
  output logic buf_wr_o,
  output logic [15:0] buf_wdata_o,
  input wire logic [15:0] buf_rdata_i,
  output logic buf_eop_o,
  output logic in_commit_o,
  // usb engine status
  input wire logic usb_bus_reset_i,
  input wire logic [15:0] first_buffer_full_i,
  input wire logic [15:0] second_buffer_full_i,
  input wire logic [15:0] next_toggle_value_i,
  input wire logic [15:0] setup_held_i,
  input wire logic [15:0] cpu_buffer_select_i,
  input wire logic [15:0] setup_setup_clobbered_i,
  input wire logic [15:0] setup_written_i,
  input wire logic [15:0] stall_req_i,
  input wire logic [15:0] unstall_req_i,
  input wire logic [15:0] setup_token_i,
  output logic [15:0] irq_clear_o,
  // dma side
  input wire logic dma_cfg_wr_i,
  input wire logic [15:0] dma_cfg_i,
  input wire logic dma_ack_i,
  input wire logic dma_word_i,
  input wire logic dma_double_i,
  input wire logic ext_eot_i,
  output logic dma_run_bit_o,
  output logic [10:0] dma_addr_o,
  output logic dma_second_o,
  output logic end_of_transfer_signal_o
);
  localparam uepbc_ptr_t BUF_END = uepbc_ptr_t'(BUF_BYTES + 2);

  function automatic logic f_is_buf_wr(input logic [7:0] c);
    return (c[7:4] == 4'h0) && (c[3:0] != 4'h0);
  endfunction
  function automatic logic f_is_buf_rd(input logic [7:0] c);
    return (c[7:4] == 4'h1) && (c[3:0] != 4'h1);
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic rst_all;
  logic soft_rst;
  logic cmd_stb;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] code;
  uepbc_phase_e phase;
  logic [3:0] ep;
  uepbc_ptr_t ptr;
  logic [15:0] pkt_len;
  logic [15:0] dma_byte_counter;
  logic [15:0] dma_remaining_count;
  logic count_terminate_enable;
  logic [15:0] endpoint_halted;
  logic [15:0] setup_clobbered;
  logic [7:0] endpoint_status_word;
  logic [15:0] dma_step;
  logic [15:0] next_count;
  uepbc_ptr_t next_dma_addr;

  // f6 is turned into one extra reset cycle for every register but soft_rst
  assign rst_all = !rstn_i || soft_rst;
  assign cmd_stb = cpu_wr_i && command_data_select_i;
  assign wr_stb = cpu_wr_i && !command_data_select_i;
  assign rd_stb = cpu_rd_i && !command_data_select_i;
  assign code = cpu_data_i[7:0];

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= cmd_stb && (code == `UEPBC_CMD_SOFT_RST);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      phase <= UEPBC_IDLE;
      ep <= 4'h0;
    end else if (cmd_stb) begin
      ep <= code[3:0];
      if (f_is_buf_wr(code)) begin
        phase <= UEPBC_BUF_W;
      end else if (f_is_buf_rd(code)) begin
        phase <= UEPBC_BUF_R;
      end else if (code[7:4] == `UEPBC_CMD_STAT_HI) begin
        phase <= UEPBC_STAT;
      end else if (code == `UEPBC_CMD_CNT_WR) begin
        phase <= UEPBC_CNT_W;
      end else if (code == `UEPBC_CMD_CNT_RD) begin
        phase <= UEPBC_CNT_R;
      end else begin
        phase <= UEPBC_IDLE;
      end
    end
  end

  // ----------------------------------------
  // buffer pointer and framing
  // ----------------------------------------
  // no bound check: overruns and wrong direction are the cpu's problem
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      ptr <= '0;
    end else if (cmd_stb) begin
      ptr <= '0;
    end else if ((wr_stb && phase == UEPBC_BUF_W) ||
                 (rd_stb && phase == UEPBC_BUF_R)) begin
      ptr <= ptr + `UEPBC_PTR_STEP;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      pkt_len <= 16'h0000;
    end else if (ptr == '0 && ((rd_stb && phase == UEPBC_BUF_R) ||
                 (wr_stb && phase == UEPBC_BUF_W))) begin
      pkt_len <= rd_stb ? buf_rdata_i : cpu_data_i;
    end
  end

  assign buf_ep_o = ep;
  assign buf_addr_o = ptr;
  assign buf_wr_o = wr_stb && (phase == UEPBC_BUF_W);
  assign buf_wdata_o = cpu_data_i;
  // last word once pointer covers the length word plus pkt_len bytes
  assign buf_eop_o = (phase == UEPBC_BUF_R) && (ptr != '0) &&
                     ({5'h00, ptr} >= pkt_len);

  // ----------------------------------------
  // endpoint status
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      endpoint_halted <= 16'h0000;
    end else begin
      // stall beats a same-cycle unstall or setup token
      endpoint_halted <= stall_req_i |
        (endpoint_halted & ~unstall_req_i & ~setup_token_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      setup_clobbered <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (setup_setup_clobbered_i[i]) begin
          setup_clobbered[i] <= 1'b1;
        end else if (rd_stb && phase == UEPBC_STAT && ep == 4'(i) &&
                     setup_written_i[i]) begin
          setup_clobbered[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    endpoint_status_word = `UEPBC_STAT_RST;
    endpoint_status_word[`UEPBC_ST_HALT] = endpoint_halted[ep];
    endpoint_status_word[`UEPBC_ST_FULL1] = second_buffer_full_i[ep];
    endpoint_status_word[`UEPBC_ST_FULL0] = first_buffer_full_i[ep];
    endpoint_status_word[`UEPBC_ST_TOGGLE] = next_toggle_value_i[ep];
    endpoint_status_word[`UEPBC_ST_CLOB] = setup_clobbered[ep];
    endpoint_status_word[`UEPBC_ST_SETUP] = setup_held_i[ep];
    endpoint_status_word[`UEPBC_ST_CPU_BUFFER_SELECT] = cpu_buffer_select_i[ep];
  end

  // ----------------------------------------
  // read data path
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      cpu_data_o <= 16'h0000;
      cpu_rvalid_o <= 1'b0;
      irq_clear_o <= 16'h0000;
    end else begin
      cpu_rvalid_o <= rd_stb;
      irq_clear_o <= 16'h0000;
      if (rd_stb) begin
        unique case (phase)
          UEPBC_CNT_R: cpu_data_o <= dma_remaining_count;
          UEPBC_STAT: begin
            cpu_data_o <= {8'h00, endpoint_status_word};
            irq_clear_o <= 16'h0001 << ep;
          end
          UEPBC_BUF_R: cpu_data_o <= buf_rdata_i;
          UEPBC_IDLE, UEPBC_CNT_W, UEPBC_BUF_W: cpu_data_o <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // dma counter and run control
  // ----------------------------------------
  assign dma_step = dma_word_i ? 16'h0002 : 16'h0001;
  assign next_count = (dma_remaining_count > dma_step) ?
                      dma_remaining_count - dma_step : 16'h0000;

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      dma_byte_counter <= `UEPBC_CNT_RST;
    end else if (wr_stb && phase == UEPBC_CNT_W) begin
      dma_byte_counter <= cpu_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      dma_run_bit_o <= 1'b0;
      count_terminate_enable <= 1'b0;
    end else if (dma_cfg_wr_i) begin
      dma_run_bit_o <= dma_cfg_i[`UEPBC_CFG_RUN_BIT];
      count_terminate_enable <= dma_cfg_i[`UEPBC_CFG_CTE_BIT];
    end else if (usb_bus_reset_i || ext_eot_i) begin
      dma_run_bit_o <= 1'b0;
    end else if (dma_run_bit_o && dma_ack_i && count_terminate_enable &&
                 next_count == 16'h0000) begin
      dma_run_bit_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      dma_remaining_count <= `UEPBC_CNT_RST;
    end else if (dma_cfg_wr_i && dma_cfg_i[`UEPBC_CFG_RUN_BIT]) begin
      dma_remaining_count <= dma_byte_counter;
    end else if (wr_stb && phase == UEPBC_CNT_W && !dma_run_bit_o) begin
      dma_remaining_count <= cpu_data_i;
    end else if (dma_run_bit_o && dma_ack_i) begin
      dma_remaining_count <= next_count;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      end_of_transfer_signal_o <= 1'b0;
    end else begin
      end_of_transfer_signal_o <= dma_run_bit_o && dma_ack_i &&
        count_terminate_enable && !dma_cfg_wr_i &&
        next_count == 16'h0000;
    end
  end

  // ----------------------------------------
  // dma buffer walk
  // ----------------------------------------
  assign next_dma_addr = dma_addr_o + uepbc_ptr_t'(dma_step);

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      dma_addr_o <= `UEPBC_DMA_START;
      dma_second_o <= 1'b0;
    end else if (dma_cfg_wr_i && dma_cfg_i[`UEPBC_CFG_RUN_BIT]) begin
      dma_addr_o <= `UEPBC_DMA_START;
      dma_second_o <= 1'b0;
    end else if (dma_run_bit_o && dma_ack_i) begin
      if (next_dma_addr >= BUF_END) begin
        // wrap past the length word of whichever buffer comes next
        dma_addr_o <= `UEPBC_DMA_START;
        dma_second_o <= dma_double_i && !dma_second_o;
      end else begin
        dma_addr_o <= next_dma_addr;
      end
    end
  end

  // in buffer leaves only when full, or early on an external eot
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      in_commit_o <= 1'b0;
    end else begin
      in_commit_o <= (buf_wr_o && ptr != '0 &&
                      ptr + `UEPBC_PTR_STEP >= BUF_END) ||
                     (dma_run_bit_o && ext_eot_i) ||
                     (dma_run_bit_o && dma_ack_i &&
                      next_dma_addr >= BUF_END);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_soft_reset_clears: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    cmd_stb && code == `UEPBC_CMD_SOFT_RST |-> ##2
    dma_byte_counter == 16'h0000 && phase == UEPBC_IDLE)
    else $error("soft reset left state behind");
  a_count_write: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    wr_stb && phase == UEPBC_CNT_W |=>
    dma_byte_counter == $past(cpu_data_i))
    else $error("counter write lost");
  a_count_read: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    rd_stb && phase == UEPBC_CNT_R |=>
    cpu_rvalid_o && cpu_data_o == $past(dma_remaining_count))
    else $error("counter read wrong");
  a_bus_reset_keep: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    usb_bus_reset_i && !(wr_stb && phase == UEPBC_CNT_W) |=>
    $stable(dma_byte_counter) && !dma_run_bit_o)
    else $error("bus reset handling wrong");
  a_reload_on_run: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    dma_cfg_wr_i && dma_cfg_i[`UEPBC_CFG_RUN_BIT] |=>
    dma_remaining_count == $past(dma_byte_counter) &&
    dma_addr_o == `UEPBC_DMA_START)
    else $error("dma reload missing");
  a_ptr_rewind: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    cmd_stb |=> ptr == '0 and (buf_wr_o |=> ptr == 11'h002))
    else $error("pointer rewind or step wrong");
  a_dma_decrement: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    dma_run_bit_o && dma_ack_i && !dma_cfg_wr_i &&
    dma_remaining_count > 16'h0002 |=>
    dma_remaining_count == $past(dma_remaining_count) -
    $past(dma_step))
    else $error("dma count step wrong");
  a_eot_at_zero: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    end_of_transfer_signal_o |-> dma_remaining_count == 16'h0000 &&
    !dma_run_bit_o)
    else $error("eot without zero count");
  a_status_clear_irq: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    rd_stb && phase == UEPBC_STAT |=>
    irq_clear_o == (16'h0001 << $past(ep)) &&
    cpu_data_o[7:0] == $past(endpoint_status_word))
    else $error("status read effects wrong");
  a_halt_flag: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    setup_token_i[0] && !stall_req_i[0] |=> !endpoint_halted[0])
    else $error("setup token left halt set");
  a_clobber_set: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    setup_setup_clobbered_i[1] |=> setup_clobbered[1])
    else $error("clobber flag not set");
  a_eot_commit: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    dma_run_bit_o && ext_eot_i |=> in_commit_o && !dma_run_bit_o)
    else $error("external eot did not commit");
  a_second_buffer: assert property (@(posedge clk_sys_i)
    disable iff (rst_all)
    dma_run_bit_o && dma_ack_i && !dma_cfg_wr_i && dma_double_i &&
    !dma_second_o && next_dma_addr >= BUF_END |=> dma_second_o)
    else $error("no switch to secondary buffer");

  c_buf_read: cover property (@(posedge clk_sys_i) buf_eop_o && rd_stb);
  c_status_read: cover property (@(posedge clk_sys_i)
    rd_stb && phase == UEPBC_STAT);
  c_count_eot: cover property (@(posedge clk_sys_i)
    end_of_transfer_signal_o);
  c_second_buf: cover property (@(posedge clk_sys_i) $rose(dma_second_o));
endmodule
`default_nettype wire

// file: test/uepbc_buf_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------
// endpoint buffer ram seen by the block
// ----------
module uepbc_buf_model (
  // clock
  input wire logic clk_sys_i,
  // buffer port
  input wire logic [3:0] buf_ep_i,
  input wire logic [10:0] buf_addr_i,
  input wire logic buf_wr_i,
  input wire logic [15:0] buf_wdata_i,
  output logic [15:0] buf_rdata_o
);
  logic [15:0] mem [0:63];
  logic [5:0] idx;
  assign idx = {buf_ep_i, buf_addr_i[2:1]};
  // unwritten words read as a pattern, so a stale zero never matches
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'ha5c3 ^ 16'(i * 16'h0101);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (buf_wr_i) begin
      mem[idx] <= buf_wdata_i;
    end
  end
  assign buf_rdata_o = mem[idx];
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "uepbc_params.svh"
module testbench;
  import uepbc_pkg::*;
  // ----------
  // signals
  // ----------
  logic clk_sys_i = 1'b0, rstn_i = 1'b0;
  logic cpu_wr_i = 1'b0, cpu_rd_i = 1'b0, command_data_select_i = 1'b0;
  logic [15:0] cpu_data_i = 16'h0, cpu_data_o, buf_wdata_o, buf_rdata_i;
  logic cpu_rvalid_o, buf_wr_o, buf_eop_o, in_commit_o, dma_run_bit_o;
  logic [3:0] buf_ep_o;
  logic [10:0] buf_addr_o, dma_addr_o;
  logic dma_second_o, end_of_transfer_signal_o, e, c;
  logic usb_bus_reset_i = 1'b0, dma_cfg_wr_i = 1'b0, dma_ack_i = 1'b0;
  logic dma_word_i = 1'b0, dma_double_i = 1'b0, ext_eot_i = 1'b0;
  logic [15:0] dma_cfg_i = 16'h0, irq_clear_o, d, x, hv;
  logic [15:0] first_buffer_full_i = 16'h0, second_buffer_full_i = 16'h0;
  logic [15:0] next_toggle_value_i = 16'h0, setup_held_i = 16'h0;
  logic [15:0] cpu_buffer_select_i = 16'h0, setup_setup_clobbered_i = 16'h0;
  logic [15:0] setup_written_i = 16'h0, stall_req_i = 16'h0;
  logic [15:0] unstall_req_i = 16'h0, setup_token_i = 16'h0;
  logic [15:0] bmem [16][3];
  int mismatches = 0, cmp_count = 0, cyc = 0, prog, rem;

  uepbc_core #(.BUF_BYTES(8)) i_uepbc_core (.clk_sys_i, .rstn_i,
    .cpu_wr_i, .cpu_rd_i, .command_data_select_i, .cpu_data_i,
    .cpu_data_o, .cpu_rvalid_o, .buf_ep_o, .buf_addr_o, .buf_wr_o,
    .buf_wdata_o, .buf_rdata_i, .buf_eop_o, .in_commit_o,
    .usb_bus_reset_i, .first_buffer_full_i, .second_buffer_full_i,
    .next_toggle_value_i, .setup_held_i, .cpu_buffer_select_i,
    .setup_setup_clobbered_i, .setup_written_i, .stall_req_i, .unstall_req_i,
    .setup_token_i, .irq_clear_o, .dma_cfg_wr_i, .dma_cfg_i, .dma_ack_i,
    .dma_word_i, .dma_double_i, .ext_eot_i, .dma_run_bit_o, .dma_addr_o,
    .dma_second_o, .end_of_transfer_signal_o);
  uepbc_buf_model i_uepbc_buf_model (.clk_sys_i, .buf_ep_i(buf_ep_o),
    .buf_addr_i(buf_addr_o), .buf_wr_i(buf_wr_o),
    .buf_wdata_i(buf_wdata_o), .buf_rdata_o(buf_rdata_i));

  always #2 clk_sys_i = ~clk_sys_i;
  // ----------
  // tasks
  // ----------
  task automatic stop_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // strobes stay up through exactly one sampling edge
  task automatic cpu(input logic cmd, rd, input logic [15:0] dat);
    command_data_select_i = cmd;
    cpu_data_i = dat;
    cpu_rd_i = rd;
    cpu_wr_i = ~rd;
    tick(1);
    cpu_rd_i = 1'b0;
    cpu_wr_i = 1'b0;
  endtask
  task automatic op(input logic [7:0] code);
    cpu(1'b1, 1'b0, {8'($urandom), code});
  endtask
  task automatic rdw(output logic [15:0] v);
    cpu(1'b0, 1'b1, 16'($urandom));
    check("read valid", {15'h0, cpu_rvalid_o}, 16'h1);
    v = cpu_data_o;
  endtask
  task automatic cfg(input logic [15:0] v);
    dma_cfg_i = v;
    dma_cfg_wr_i = 1'b1;
    tick(1);
    dma_cfg_wr_i = 1'b0;
  endtask
  task automatic ack(input logic w);
    dma_word_i = w;
    dma_ack_i = 1'b1;
    tick(1);
    dma_ack_i = 1'b0;
    rem = rem - (w ? 2 : 1);
  endtask
  task automatic wr_cnt(input logic [15:0] v);
    op(`UEPBC_CMD_CNT_WR);
    cpu(1'b0, 1'b0, v);
  endtask
  task automatic rd_cnt(input int exp);
    op(`UEPBC_CMD_CNT_RD);
    rdw(d);
    check("dma count", d, 16'(exp));
  endtask
  task automatic watch();
    e = 1'b0;
    c = 1'b0;
    repeat (3) begin
      e |= end_of_transfer_signal_o;
      c |= in_commit_o;
      tick(1);
    end
  endtask
  task automatic stat_all(input logic [15:0] halt, clob);
    for (int ep = 0; ep < 16; ep++) begin
      op({`UEPBC_CMD_STAT_HI, 4'(ep)});
      rdw(d);
      x = {8'h0, halt[ep], second_buffer_full_i[ep], first_buffer_full_i[ep],
        next_toggle_value_i[ep], clob[ep], setup_held_i[ep],
        cpu_buffer_select_i[ep], 1'b0};
      check("status", d, x);
      check("irq clear", irq_clear_o, 16'h1 << ep);
    end
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // ----------
  // sequence
  // ----------
  initial begin
    void'($urandom(94));
    tick(8);
    rstn_i = 1'b1;
    rd_cnt(0);
    prog = $urandom_range(200, 16);
    wr_cnt(16'(prog));
    rd_cnt(prog);
    cfg(16'h0008);
    rem = prog;
    check("run", {15'h0, dma_run_bit_o}, 16'h1);
    check("dma start", {5'h0, dma_addr_o}, 16'h2);
    repeat (6) ack(1'($urandom));
    check("second", {15'h0, dma_second_o}, 16'h0);
    rd_cnt(rem);
    cfg(16'h0000);
    check("run", {15'h0, dma_run_bit_o}, 16'h0);
    cfg(16'h0008);
    rd_cnt(prog);
    usb_bus_reset_i = 1'b1;
    tick(1);
    usb_bus_reset_i = 1'b0;
    check("run", {15'h0, dma_run_bit_o}, 16'h0);
    rd_cnt(prog);
    // count down to zero with termination enabled
    wr_cnt(16'h0003);
    cfg(16'h8008);
    rem = 3;
    ack(1'b1);
    watch();
    check("eot early", {15'h0, e}, 16'h0);
    ack(1'b0);
    watch();
    check("eot", {15'h0, e}, 16'h1);
    rd_cnt(rem);
    // double buffered dma runs past the primary end
    cfg(16'h0000);
    dma_double_i = 1'b1;
    wr_cnt(16'h0010);
    cfg(16'h0008);
    repeat (4) ack(1'b1);
    check("second", {15'h0, dma_second_o}, 16'h1);
    dma_double_i = 1'b0;
    ext_eot_i = 1'b1;
    tick(1);
    ext_eot_i = 1'b0;
    watch();
    check("commit", {15'h0, c}, 16'h1);
    op(`UEPBC_CMD_SOFT_RST);
    tick(2);
    check("run", {15'h0, dma_run_bit_o}, 16'h0);
    rd_cnt(0);
    // buffer writes then reads; three words per endpoint, fewer than the buffer holds
    for (int ep = 1; ep < 16; ep++) begin
      op(8'(ep));
      check("ep", {12'h0, buf_ep_o}, 16'(ep));
      for (int w = 0; w < 3; w++) begin
        check("ptr", {5'h0, buf_addr_o}, 16'(2 * w));
        bmem[ep][w] = (w == 0) ? 16'h0004 : 16'($urandom);
        cpu(1'b0, 1'b0, bmem[ep][w]);
      end
    end
    for (int ep = 0; ep < 16; ep++) begin
      if (ep == 1) continue;
      op(8'h10 | 8'(ep));
      check("ep", {12'h0, buf_ep_o}, 16'(ep));
      check("ptr", {5'h0, buf_addr_o}, 16'h0);
      for (int w = 0; w < 3; w++) begin
        rdw(d);
        if (ep != 0) check("buf data", d, bmem[ep][w]);
        if (ep != 0) check("eop", {15'h0, buf_eop_o}, 16'(w >= 1));
      end
    end
    // status words with random engine state
    first_buffer_full_i = 16'($urandom);
    second_buffer_full_i = 16'($urandom);
    next_toggle_value_i = 16'($urandom);
    setup_held_i = 16'($urandom);
    cpu_buffer_select_i = 16'($urandom);
    hv = 16'($urandom);
    // firmware reads the clobber bits before it stalls any endpoint
    stat_all(16'h0, 16'h0);
    stall_req_i = hv;
    setup_setup_clobbered_i = 16'hffff;
    tick(1);
    stall_req_i = 16'h0;
    setup_setup_clobbered_i = 16'h0;
    stat_all(hv, 16'hffff);
    setup_written_i = 16'hffff;
    stat_all(hv, 16'hffff);
    unstall_req_i = hv & 16'hfffc;
    setup_token_i = hv & 16'h0003;
    tick(1);
    unstall_req_i = 16'h0;
    setup_token_i = 16'h0;
    stat_all(16'h0, 16'h0);
    stop_test();
  end
endmodule
`default_nettype wire
